/* File: ssp_peer.sv */
// behavioural mode-0 serial peripheral on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module ssp_peer
(
    // link from the port
    input wire logic        sck,
    input wire logic        ss_n,
    input wire logic        mosi,
    output logic            miso,
    // bench side
    input wire logic [15:0] reply,
    input wire logic [3:0]  size,
    output logic [15:0]     got
);
    int idx;

    initial
    begin
        miso = 1'b0;
        got = 16'h0;
        idx = 0;
    end
    // msb first, first bit ready as select falls
    always @(negedge ss_n)
    begin
        idx = size;
        got = 16'h0;
        miso = reply[idx];
    end
    always @(posedge sck)
        if (!ss_n)
            got = {got[14:0], mosi};
    always @(negedge sck)
        if (!ss_n && idx > 0)
        begin
            idx--;
            miso = reply[idx];
        end
    // released line: no stale value may pass for data
    always @(posedge ss_n)
        miso = ~miso;
endmodule
`default_nettype wire

/* File: ssp_pkg.sv */
// constants, register map and types of the synchronous serial port register block
// Behaviour
// RULE1: slave select bit 1 makes the port a slave; 0 (reset) makes it master.
// RULE2: port enable bit 1 gates all serial activity; resets to 0.
// RULE3: loopback bit feeds transmit shifter output into receive shifter internally.
// RULE4: data register read returns receive FIFO head; frames stored at write pointer.
// RULE5: data register write queues transmit FIFO; shifter sends entries at bit rate.
// RULE6: short frames take right-justified transmit data; upper unused bits ignored.
// RULE7: short received frames stored right-justified.
// RULE8: busy flag set while a frame moves or transmit FIFO holds data.
// RULE9: status bit 3 receive FIFO full, bit 2 receive FIFO not empty; reset 0.
// RULE10: status bit 1 transmit FIFO not full, bit 0 transmit FIFO empty; reset 1.
// RULE11: even prescale divisor divides the clock; bit 0 always reads zero.
// RULE12: mask bit 1 enables its interrupt; mask readable, clears at reset.
// RULE13: transmit interrupt when transmit FIFO half empty or emptier.
// RULE14: receive level interrupt when receive FIFO is half full.
// RULE15: timeout interrupt when receive data sits unread past the timeout.
// RULE16: overrun interrupt when a frame arrives with receive FIFO full.
// RULE17: raw status shows unmasked conditions, ignores writes, transmit bit resets 1.
// RULE18: masked status is raw ANDed with mask, ignores writes, resets 0.
// RULE19: write-only clear: bit 1 clears timeout, bit 0 clears overrun.
// RULE20: dma control bit 1 transmit, bit 0 receive request enable; reset 0.
// RULE21: software changes the slave select bit only while the port is disabled.
// RULE22: combined interrupt output is the OR of the four masked states.
// RULE23: timeout is 32 bit periods with receive FIFO non-empty and unread.
package ssp_pkg;

    // register byte addresses, low six address bits
    localparam logic [5:0] ADDR_CTRL_B    = 6'h04;
    localparam logic [5:0] ADDR_DATA      = 6'h08;
    localparam logic [5:0] ADDR_STATUS    = 6'h10;
    localparam logic [5:0] ADDR_PRESCALE  = 6'h14;
    localparam logic [5:0] ADDR_MASK      = 6'h18;
    localparam logic [5:0] ADDR_RAW       = 6'h1c;
    localparam logic [5:0] ADDR_MASKED    = 6'h20;
    localparam logic [5:0] ADDR_CLEAR     = 6'h24;
    localparam logic [5:0] ADDR_DMA       = 6'h28;

    // port_control_b fields
    localparam int CTRL_SLAVE_BIT = 2;
    localparam int CTRL_EN_BIT    = 1;
    localparam int CTRL_LOOP_BIT  = 0;

    // interrupt bit positions, shared by mask, raw, masked and clear
    localparam int IRQ_TX_BIT  = 3;
    localparam int IRQ_RX_BIT  = 2;
    localparam int IRQ_TMO_BIT = 1;
    localparam int IRQ_OVR_BIT = 0;

    // port_status fields
    localparam int STAT_BUSY_BIT  = 4;
    localparam int STAT_RFF_BIT   = 3;
    localparam int STAT_RNE_BIT   = 2;
    localparam int STAT_TNF_BIT   = 1;
    localparam int STAT_TFE_BIT   = 0;

    // dma_control fields
    localparam int DMA_TX_BIT = 1;
    localparam int DMA_RX_BIT = 0;

    // reset values
    localparam logic [2:0] CTRL_RST     = 3'h0;
    localparam logic [7:0] PRESCALE_RST = 8'h00;
    localparam logic [3:0] MASK_RST     = 4'h0;
    localparam logic [1:0] DMA_RST      = 2'h0;

    // fifo geometry and thresholds
    localparam logic [3:0] FIFO_DEPTH = 4'h8;
    localparam logic [3:0] FIFO_HALF  = 4'h4;

    // receive timeout in bit periods
    localparam logic [5:0] RX_TMO_BITS = 6'h20;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SSP_IDLE  = 2'h0,
        SSP_SHIFT = 2'h1
    } ssp_state_t;

    typedef struct packed {
        // bus side
        logic              aw_ok;
        logic [5:0]        aw_addr;
        logic              w_ok;
        logic [15:0]       w_data;
        logic [1:0]        w_strb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [1:0]        rresp;
        logic [15:0]       rdata;
        // software state
        logic [2:0]        ctrl;
        logic [7:0]        prescale;
        logic [3:0]        mask;
        logic [1:0]        dma;
        logic              tmo_raw;
        logic              ovr_raw;
        // fifos
        logic [7:0][15:0]  txq;
        logic [2:0]        tx_wp;
        logic [2:0]        tx_rp;
        logic [3:0]        tx_cnt;
        logic [7:0][15:0]  rxq;
        logic [2:0]        rx_wp;
        logic [2:0]        rx_rp;
        logic [3:0]        rx_cnt;
        // serial engine
        ssp_state_t        state;
        logic [15:0]       sh;
        logic [4:0]        bcnt;
        logic              rxbit;
        logic              sck;
        logic              cs_n;
        logic              txo;
        logic [6:0]        pdiv;
        logic              phase;
        logic [5:0]        tmo;
        // pin synchronisers
        logic              sck_s1;
        logic              sck_s2;
        logic              sck_s3;
        logic              ss_s1;
        logic              ss_s2;
        logic              rx_s1;
        logic              rx_s2;
    } ssp_regs_t;

endpackage

/* File: ssp_port.sv */
// synchronous serial port: register slave, fifos, serial engine and interrupt status
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module ssp_port
    import ssp_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // axi4-lite write
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // frame size code from the other control register, bits minus one
    input  wire logic [3:0]  data_size,
    // serial pins
    output logic             port_sck_o,
    output logic             port_sck_oe_n,
    input  wire logic        port_sck_i,
    output logic             port_ss_n_o,
    output logic             port_ss_oe_n,
    input  wire logic        port_ss_n_i,
    output logic             serial_tx_pin,
    output logic             serial_tx_oe_n,
    input  wire logic        serial_rx_pin,
    // interrupts and dma requests
    output logic             tx_level_irq,
    output logic             rx_level_irq,
    output logic             rx_timeout_irq,
    output logic             rx_overrun_irq,
    output logic             port_irq,
    output logic             tx_dma_req,
    output logic             rx_dma_req
);

    ssp_regs_t s;
    ssp_regs_t n;

    logic        slave_select_bit;
    logic        port_enable_bit;
    logic        loopback_bit;
    logic [3:0]  raw;
    logic [3:0]  masked;
    logic [15:0] frame_mask;

    assign slave_select_bit = s.ctrl[CTRL_SLAVE_BIT];
    assign port_enable_bit  = s.ctrl[CTRL_EN_BIT];
    assign loopback_bit     = s.ctrl[CTRL_LOOP_BIT];
    assign frame_mask       = 16'hffff >> (4'hf - data_size); // [RULE6] [RULE7]

    always_comb
    begin
        raw              = 4'h0;
        raw[IRQ_TX_BIT]  = (s.tx_cnt <= FIFO_HALF); // [RULE13]
        raw[IRQ_RX_BIT]  = (s.rx_cnt >= FIFO_HALF); // [RULE14]
        raw[IRQ_TMO_BIT] = s.tmo_raw;
        raw[IRQ_OVR_BIT] = s.ovr_raw;
    end

    assign masked = raw & s.mask; // [RULE18]

    // bus handshake outputs
    assign awready = !s.aw_ok;
    assign wready  = !s.w_ok;
    assign arready = !s.rvalid;
    assign bvalid  = s.bvalid;
    assign bresp   = s.bresp;
    assign rvalid  = s.rvalid;
    assign rresp   = s.rresp;
    assign rdata   = {16'h0000, s.rdata};

    assign tx_level_irq   = masked[IRQ_TX_BIT];
    assign rx_level_irq   = masked[IRQ_RX_BIT];
    assign rx_timeout_irq = masked[IRQ_TMO_BIT];
    assign rx_overrun_irq = masked[IRQ_OVR_BIT];
    assign port_irq       = |masked; // [RULE22]
    assign tx_dma_req     = s.dma[DMA_TX_BIT] && (s.tx_cnt != FIFO_DEPTH); // [RULE20]
    assign rx_dma_req     = s.dma[DMA_RX_BIT] && (s.rx_cnt != 4'h0); // [RULE20]

    // pins: master drives clock and select, a selected slave drives data
    assign port_sck_o     = s.sck;
    assign port_ss_n_o    = s.cs_n;
    assign port_sck_oe_n  = !(port_enable_bit && !slave_select_bit);
    assign port_ss_oe_n   = !(port_enable_bit && !slave_select_bit);
    assign serial_tx_pin  = s.txo;
    assign serial_tx_oe_n = !(port_enable_bit && (!slave_select_bit || !s.ss_s2));

    logic        wr_go;
    logic        rd_go;
    logic [15:0] wm;
    logic [15:0] wv;
    logic        tx_push;
    logic        tx_pop;
    logic        rx_push;
    logic        rx_pop;
    logic [15:0] rx_word;
    logic        half_tick;
    logic        bit_tick;
    logic        rise;
    logic        fall;
    logic        src;
    logic [7:0]  div;

    always_comb
    begin
        n         = s;
        wr_go     = s.aw_ok && s.w_ok && !s.bvalid;
        rd_go     = arvalid && !s.rvalid;
        wm        = {{8{s.w_strb[1]}}, {8{s.w_strb[0]}}};
        wv        = s.w_data & wm;
        tx_push   = 1'b0;
        tx_pop    = 1'b0;
        rx_push   = 1'b0;
        rx_pop    = 1'b0;
        rx_word   = 16'h0000;
        rise      = 1'b0;
        fall      = 1'b0;
        // divisor below two behaves as two
        div       = (s.prescale < 8'h02) ? 8'h02 : s.prescale; // [RULE11]
        half_tick = (s.pdiv == 7'(div[7:1] - 7'h01));
        bit_tick  = half_tick && s.phase;
        src       = loopback_bit ? s.txo : s.rx_s2; // [RULE3]

        // synchronisers: stage one feeds stage two; the clock adds a third stage for edge detection
        n.sck_s1 = port_sck_i;
        n.sck_s2 = s.sck_s1;
        n.sck_s3 = s.sck_s2;
        n.ss_s1  = port_ss_n_i;
        n.ss_s2  = s.ss_s1;
        n.rx_s1  = serial_rx_pin;
        n.rx_s2  = s.rx_s1;

        // bit-rate divider, free running except for a restart as a master frame starts
        n.pdiv = half_tick ? 7'h00 : 7'(s.pdiv + 7'h01); // [RULE11]
        if (half_tick)
        begin
            n.phase = !s.phase;
        end

        // write channel capture, either order
        if (awvalid && !s.aw_ok)
        begin
            n.aw_ok   = 1'b1;
            n.aw_addr = awaddr[5:0];
        end
        if (wvalid && !s.w_ok)
        begin
            n.w_ok   = 1'b1;
            n.w_data = wdata[15:0];
            n.w_strb = wstrb[1:0];
        end
        if (s.bvalid && bready)
        begin
            n.bvalid = 1'b0;
        end
        if (wr_go)
        begin
            n.aw_ok  = 1'b0;
            n.w_ok   = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = RESP_OKAY;
            unique case (s.aw_addr)
                ADDR_CTRL_B:
                    if (s.w_strb[0])
                    begin
                        n.ctrl[CTRL_EN_BIT]   = s.w_data[CTRL_EN_BIT]; // [RULE2]
                        n.ctrl[CTRL_LOOP_BIT] = s.w_data[CTRL_LOOP_BIT]; // [RULE3]
                        // mode held while running so a live frame never flips role
                        if (!port_enable_bit)
                        begin
                            n.ctrl[CTRL_SLAVE_BIT] = s.w_data[CTRL_SLAVE_BIT]; // [RULE1] [RULE21]
                        end
                    end
                ADDR_DATA:
                    // full fifo drops the write silently
                    if (s.tx_cnt != FIFO_DEPTH)
                    begin
                        tx_push = 1'b1; // [RULE5]
                    end
                ADDR_PRESCALE:
                    if (s.w_strb[0])
                    begin
                        n.prescale = {s.w_data[7:1], 1'b0}; // [RULE11]
                    end
                ADDR_MASK:
                    if (s.w_strb[0])
                    begin
                        n.mask = s.w_data[3:0]; // [RULE12]
                    end
                ADDR_CLEAR:
                    if (s.w_strb[0])
                    begin
                        if (s.w_data[IRQ_TMO_BIT])
                        begin
                            n.tmo_raw = 1'b0; // [RULE19]
                        end
                        if (s.w_data[IRQ_OVR_BIT])
                        begin
                            n.ovr_raw = 1'b0; // [RULE19]
                        end
                    end
                ADDR_DMA:
                    if (s.w_strb[0])
                    begin
                        n.dma = s.w_data[1:0]; // [RULE20]
                    end
                ADDR_STATUS, ADDR_RAW, ADDR_MASKED:
                    n.bresp = RESP_OKAY; // [RULE17] [RULE18]
                default:
                    n.bresp = RESP_SLVERR;
            endcase
        end

        // read channel
        if (s.rvalid && rready)
        begin
            n.rvalid = 1'b0;
        end
        if (rd_go)
        begin
            n.rvalid = 1'b1;
            n.rresp  = RESP_OKAY;
            n.rdata  = 16'h0000;
            unique case (araddr[5:0])
                ADDR_CTRL_B:   n.rdata = {13'h0, s.ctrl};
                ADDR_DATA:
                begin
                    n.rdata = s.rxq[s.rx_rp]; // [RULE4]
                    rx_pop  = (s.rx_cnt != 4'h0);
                end
                ADDR_STATUS:
                begin
                    n.rdata[STAT_BUSY_BIT] = (s.state != SSP_IDLE) || (s.tx_cnt != 4'h0); // [RULE8]
                    n.rdata[STAT_RFF_BIT]  = (s.rx_cnt == FIFO_DEPTH); // [RULE9]
                    n.rdata[STAT_RNE_BIT]  = (s.rx_cnt != 4'h0); // [RULE9]
                    n.rdata[STAT_TNF_BIT]  = (s.tx_cnt != FIFO_DEPTH); // [RULE10]
                    n.rdata[STAT_TFE_BIT]  = (s.tx_cnt == 4'h0); // [RULE10]
                end
                ADDR_PRESCALE: n.rdata = {8'h00, s.prescale};
                ADDR_MASK:     n.rdata = {12'h000, s.mask}; // [RULE12]
                ADDR_RAW:      n.rdata = {12'h000, raw}; // [RULE17]
                ADDR_MASKED:   n.rdata = {12'h000, masked}; // [RULE18]
                ADDR_CLEAR:    n.rdata = 16'h0000;
                ADDR_DMA:      n.rdata = {14'h0, s.dma};
                default:       n.rresp = RESP_SLVERR;
            endcase
        end

        // edge events for the shifter
        if (slave_select_bit)
        begin
            rise = s.sck_s2 && !s.sck_s3;
            fall = !s.sck_s2 && s.sck_s3;
        end
        else
        begin
            rise = half_tick && !s.sck;
            fall = half_tick && s.sck;
        end

        unique case (s.state)
            SSP_IDLE:
            begin
                n.sck  = 1'b0;
                n.cs_n = 1'b1;
                if (port_enable_bit) // [RULE2]
                begin
                    if (!slave_select_bit && (s.tx_cnt != 4'h0))
                    begin
                        tx_pop  = 1'b1; // [RULE5]
                        n.sh    = s.txq[s.tx_rp];
                        n.bcnt  = {1'b0, data_size} + 5'h01;
                        n.cs_n  = 1'b0;
                        n.pdiv  = 7'h00;
                        n.state = SSP_SHIFT;
                    end
                    else if (slave_select_bit && !s.ss_s2)
                    begin
                        // empty fifo answers with zeros
                        tx_pop  = (s.tx_cnt != 4'h0);
                        n.sh    = tx_pop ? s.txq[s.tx_rp] : 16'h0000;
                        n.bcnt  = {1'b0, data_size} + 5'h01;
                        n.state = SSP_SHIFT;
                    end
                end
            end
            SSP_SHIFT:
            begin
                if (!port_enable_bit || (slave_select_bit && s.ss_s2)) // [RULE2]
                begin
                    n.state = SSP_IDLE;
                end
                else if (rise)
                begin
                    n.sck   = !slave_select_bit;
                    n.rxbit = src;
                    if (s.bcnt == 5'h01)
                    begin
                        rx_push = 1'b1; // [RULE4]
                        rx_word = {s.sh[14:0], src} & frame_mask; // [RULE7]
                    end
                end
                else if (fall)
                begin
                    n.sck = 1'b0;
                    if (s.bcnt == 5'h01)
                    begin
                        n.state = SSP_IDLE;
                    end
                    else
                    begin
                        n.sh   = {s.sh[14:0], s.rxbit};
                        n.bcnt = 5'(s.bcnt - 5'h01);
                    end
                end
            end
            default:
                n.state = SSP_IDLE;
        endcase
        n.txo = n.sh[data_size]; // [RULE6]

        // fifo bookkeeping
        if (tx_push)
        begin
            n.txq[s.tx_wp] = wv; // [RULE5]
            n.tx_wp        = 3'(s.tx_wp + 3'h1);
        end
        if (tx_pop)
        begin
            n.tx_rp = 3'(s.tx_rp + 3'h1);
        end
        n.tx_cnt = 4'(s.tx_cnt + {3'h0, tx_push} - {3'h0, tx_pop});

        if (rx_pop)
        begin
            n.rx_rp = 3'(s.rx_rp + 3'h1);
        end
        if (rx_push && (s.rx_cnt == FIFO_DEPTH))
        begin
            n.ovr_raw = 1'b1; // [RULE16]
            rx_push   = 1'b0;
        end
        if (rx_push)
        begin
            n.rxq[s.rx_wp] = rx_word; // [RULE4]
            n.rx_wp        = 3'(s.rx_wp + 3'h1);
        end
        n.rx_cnt = 4'(s.rx_cnt + {3'h0, rx_push} - {3'h0, rx_pop});

        // receive timeout, restarted by a data register read or an empty fifo
        if (rx_pop || (s.rx_cnt == 4'h0))
        begin
            n.tmo = 6'h00; // [RULE23]
        end
        else if (bit_tick)
        begin
            if (6'(s.tmo + 6'h01) == RX_TMO_BITS)
            begin
                n.tmo     = 6'h00;
                n.tmo_raw = 1'b1; // [RULE15] [RULE23]
            end
            else
            begin
                n.tmo = 6'(s.tmo + 6'h01);
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s          <= '0;
            s.ctrl     <= CTRL_RST; // [RULE1] [RULE2]
            s.prescale <= PRESCALE_RST;
            s.mask     <= MASK_RST; // [RULE12]
            s.dma      <= DMA_RST; // [RULE20]
            s.state    <= SSP_IDLE;
            s.cs_n     <= 1'b1;
            s.ss_s1    <= 1'b1;
            s.ss_s2    <= 1'b1;
        end
        else
        begin
            s <= n;
        end
    end

endmodule
`default_nettype wire

/* File: ssp_port_assertions.sv */
// concurrent checks on the serial port top-level ports
`timescale 1ns/1ps
`default_nettype none
module ssp_port_assertions
    import ssp_pkg::*;
(
    // clock and reset
    input wire logic        mclk,
    input wire logic        reset_n,
    // bus answers
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [1:0]  bresp,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    // serial pins
    input wire logic        port_sck_o,
    input wire logic        port_sck_oe_n,
    input wire logic        port_ss_n_o,
    input wire logic        port_ss_oe_n,
    input wire logic        serial_tx_pin,
    // interrupts
    input wire logic        tx_level_irq,
    input wire logic        rx_level_irq,
    input wire logic        rx_timeout_irq,
    input wire logic        rx_overrun_irq,
    input wire logic        port_irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    AST_IRQ_OR: assert property (port_irq == (tx_level_irq | rx_level_irq | rx_timeout_irq | rx_overrun_irq))
        else $error("combined irq differs from the or of the four");
    AST_MASTER_OE: assert property (!port_sck_oe_n |-> !port_ss_oe_n)
        else $error("clock driven without select driven");
    AST_RDATA_HI: assert property (rvalid |-> rdata[31:16] == 16'h0)
        else $error("read data upper half not zero");
    AST_RVALID_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped before rready");
    AST_BVALID_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped before bready");
    AST_SCK_FRAME: assert property ($changed(port_sck_o) |-> !port_ss_n_o)
        else $error("serial clock moved outside a frame");
    AST_TX_STABLE: assert property (port_sck_o |-> $stable(serial_tx_pin))
        else $error("transmit bit changed while clock high");
    AST_SS_FALL: assert property ($fell(port_ss_n_o) |-> !port_sck_o ##1 !port_ss_n_o)
        else $error("clock high at frame start");
endmodule

bind ssp_port ssp_port_assertions chk_u (.mclk, .reset_n, .bvalid, .bready, .bresp, .rvalid, .rready, .rdata,
    .port_sck_o, .port_sck_oe_n, .port_ss_n_o, .port_ss_oe_n, .serial_tx_pin,
    .tx_level_irq, .rx_level_irq, .rx_timeout_irq, .rx_overrun_irq, .port_irq);
`default_nettype wire

/* File: tb_ssp_port.sv */
// self-checking bench for the serial port register block
`timescale 1ns/1ps
`default_nettype none
module tb_ssp_port
    import ssp_pkg::*;
;
    logic        mclk, reset_n, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [31:0] awaddr, wdata, araddr, rdata, d, msk;
    logic [3:0]  wstrb, data_size;
    logic [1:0]  bresp, rresp, rs;
    logic        sck, sck_oe_n, ss_n, ss_oe_n, txd, tx_oe_n, rxd;
    logic        irq_tx, irq_rx, irq_tmo, irq_ovr, port_irq, dma_tx, dma_rx;
    logic [15:0] reply, got;
    int          errors, checks;
    logic [5:0]  ra [8] = '{ADDR_CTRL_B, ADDR_STATUS, ADDR_PRESCALE, ADDR_MASK, ADDR_RAW, ADDR_MASKED,
                            ADDR_CLEAR, ADDR_DMA};
    logic [31:0] rv [8] = '{32'h0, 32'h3, 32'h0, 32'h0, 32'h8, 32'h0, 32'h0, 32'h0};

    ssp_port dut_u (.mclk, .reset_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .data_size,
        .port_sck_o(sck), .port_sck_oe_n(sck_oe_n), .port_sck_i(1'b0), .port_ss_n_o(ss_n),
        .port_ss_oe_n(ss_oe_n), .port_ss_n_i(1'b1), .serial_tx_pin(txd), .serial_tx_oe_n(tx_oe_n),
        .serial_rx_pin(rxd), .tx_level_irq(irq_tx), .rx_level_irq(irq_rx), .rx_timeout_irq(irq_tmo),
        .rx_overrun_irq(irq_ovr), .port_irq, .tx_dma_req(dma_tx), .rx_dma_req(dma_rx));
    ssp_peer peer_u (.sck, .ss_n, .mosi(txd), .miso(rxd), .reply, .size(data_size), .got);

    always #12.5 mclk = ~mclk;

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge mclk);
        awaddr <= {26'h0, a};
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic bus_rd(input logic [5:0] a);
        @(posedge mclk);
        araddr <= {26'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        rs = rresp;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
        bus_rd(a);
        chk({30'h0, rs}, {30'h0, er});
        if (er == RESP_OKAY)
            chk(d & msk, e);
    endtask
    // poll busy; the watchdog bounds a stuck port
    task automatic idle();
        bus_rd(ADDR_STATUS);
        while (d[STAT_BUSY_BIT] !== 1'b0)
            bus_rd(ADDR_STATUS);
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        errors++;
        report_and_stop();
    end

    initial
    begin
        {mclk, reset_n, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
        {awaddr, wdata, araddr} = 96'h0;
        wstrb = 4'hf;
        data_size = 4'h7;
        reply = 16'h3c;
        msk = 32'hffffffff;
        errors = 0;
        checks = 0;
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd(ra[i], rv[i], RESP_OKAY);
        $display("test 1 done");
        wr(ADDR_PRESCALE, 32'h7, RESP_OKAY);
        rd(ADDR_PRESCALE, 32'h6, RESP_OKAY);
        wr(ADDR_MASK, 32'hf, RESP_OKAY);
        rd(ADDR_MASK, 32'hf, RESP_OKAY);
        rd(ADDR_MASKED, 32'h8, RESP_OKAY);
        chk({31'h0, port_irq}, 32'h1);
        wr(ADDR_DMA, 32'h3, RESP_OKAY);
        rd(ADDR_DMA, 32'h3, RESP_OKAY);
        chk({30'h0, dma_tx, dma_rx}, 32'h2);
        wr(ADDR_RAW, 32'h0, RESP_OKAY);
        rd(ADDR_RAW, 32'h8, RESP_OKAY);
        wr(6'h30, 32'h1, RESP_SLVERR);
        rd(6'h30, 32'h0, RESP_SLVERR);
        $display("test 2 done");
        wr(ADDR_PRESCALE, 32'h8, RESP_OKAY);
        wr(ADDR_DATA, 32'h1a5, RESP_OKAY);
        wr(ADDR_CTRL_B, 32'h2, RESP_OKAY);
        idle();
        chk({16'h0, got}, 32'ha5);
        rd(ADDR_DATA, 32'h3c, RESP_OKAY);
        rd(ADDR_STATUS, 32'h3, RESP_OKAY);
        $display("test 3 done");
        wr(ADDR_CTRL_B, 32'h0, RESP_OKAY);
        for (int k = 0; k < 8; k++)
            wr(ADDR_DATA, 32'h100 + k * 32'h13, RESP_OKAY);
        rd(ADDR_STATUS, 32'h10, RESP_OKAY);
        rd(ADDR_RAW, 32'h0, RESP_OKAY);
        wr(ADDR_CTRL_B, 32'h3, RESP_OKAY);
        idle();
        rd(ADDR_STATUS, 32'hf, RESP_OKAY);
        wr(ADDR_DATA, 32'h55, RESP_OKAY);
        idle();
        // timeout may already be up here, so it is masked off
        msk = 32'hd;
        rd(ADDR_RAW, 32'hd, RESP_OKAY);
        msk = 32'hffffffff;
        repeat (400) @(posedge mclk);
        rd(ADDR_RAW, 32'hf, RESP_OKAY);
        rd(ADDR_MASKED, 32'hf, RESP_OKAY);
        chk({28'h0, irq_tx, irq_rx, irq_tmo, irq_ovr}, 32'hf);
        rd(ADDR_DATA, 32'h0, RESP_OKAY);
        wr(ADDR_CLEAR, 32'h3, RESP_OKAY);
        rd(ADDR_RAW, 32'hc, RESP_OKAY);
        for (int k = 1; k < 8; k++)
            rd(ADDR_DATA, (k * 32'h13) & 32'hff, RESP_OKAY);
        rd(ADDR_STATUS, 32'h3, RESP_OKAY);
        $display("test 4 done");
        wr(ADDR_CTRL_B, 32'h0, RESP_OKAY);
        wr(ADDR_CTRL_B, 32'h6, RESP_OKAY);
        chk({29'h0, sck_oe_n, ss_oe_n, tx_oe_n}, 32'h7);
        wr(ADDR_CTRL_B, 32'h2, RESP_OKAY);
        rd(ADDR_CTRL_B, 32'h6, RESP_OKAY);
        $display("test 5 done");
        report_and_stop();
    end
endmodule
`default_nettype wire
